// ---- rtl/pgs_deglitch.sv ----
`timescale 1ns/1ns
`default_nettype none
module pgs_deglitch import pgs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic raw_bad,
  input wire logic [DG_W-1:0] set_cyc,
  input wire logic [DG_W-1:0] clr_cyc,
  output logic bad
);

  typedef struct packed {
    logic [DG_W-1:0] cnt;
    logic q;
  } pgs_dg_t;

  pgs_dg_t s;
  pgs_dg_t next_s;
  logic [DG_W-1:0] lim;

  // Output follows only after the input held steady for the whole window
  always_comb begin
    next_s = s;
    lim = raw_bad ? set_cyc : clr_cyc;
    if (raw_bad != s.q) begin
      if (s.cnt + DG_W'(1) >= lim) begin
        next_s.q = raw_bad;
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt + DG_W'(1);
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bad = s.q;

endmodule : pgs_deglitch
`default_nettype wire

// ---- rtl/pgs_delay_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module pgs_delay_timer import pgs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [TMR_W-1:0] limit,
  output logic done
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic run;
    logic done;
  } pgs_tmr_t;

  pgs_tmr_t s;
  pgs_tmr_t next_s;

  always_comb begin
    next_s = s;
    if (stop) begin
      next_s.run = 1'b0;
      next_s.done = 1'b0;
    end else if (start) begin
      next_s.cnt = limit;
      next_s.run = 1'b1;
      next_s.done = 1'b0;
    end else if (s.run) begin
      if (s.cnt <= TMR_W'(1)) begin
        next_s.run = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule : pgs_delay_timer
`default_nettype wire

// ---- rtl/pgs_pkg.sv ----
package pgs_pkg;

  localparam int NRAIL = 5;
  localparam logic [2:0] LAST_RAIL = 3'h4;
  localparam int TMR_W = 26;
  localparam int DG_W = 17;

  // Clock and times, each in its own unit
  localparam int CLK_NS = 10;
  localparam int T_DEG_SLOW_MS = 1;
  localparam int T_DEG_FAST_US = 50;
  localparam int T_DEG_RISE_US = 10;
  localparam int T_BLANK_MS = 5;
  localparam int T_STROBE_MS = 2;
  localparam int T_HOLD_EXTRA_MS = 1;
  localparam int T_DLY_UNIT_MS = 1;

  // Least times, rounded up to whole cycles
  localparam int CYC_DEG_SLOW = (T_DEG_SLOW_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_DEG_FAST = (T_DEG_FAST_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_DEG_RISE = (T_DEG_RISE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_BLANK = (T_BLANK_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_STROBE = (T_STROBE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_HOLD_EXTRA =
    (T_HOLD_EXTRA_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_DLY_UNIT = (T_DLY_UNIT_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // Comparator thresholds in tenths of a percent of nominal
  localparam logic [10:0] UV_RELAXED = 11'h384;
  localparam logic [10:0] UV_TIGHT_BUCK12 = 11'h3C5;
  localparam logic [10:0] UV_TIGHT_OTHER = 11'h3BB;
  localparam logic [10:0] OV_TIGHT_BUCK12 = 11'h40B;
  localparam logic [10:0] OV_TIGHT_OTHER = 11'h415;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_STRICT_BIT = 8;
  localparam int STAT_OK_BIT = 5;
  localparam int STAT_BK_BIT = 6;
  localparam int STAT_FAULT_BIT = 7;
  localparam int STAT_PIN_BIT = 8;
  localparam logic [7:0] RST_DELAY = 8'h0A;
  localparam logic OD_LEVEL = 1'h0;

  typedef enum logic [1:0] {
    PGS_OK_LOW = 2'b00,
    PGS_OK_WAIT = 2'b01,
    PGS_OK_HIGH = 2'b10
  } pgs_ok_t;

  typedef enum logic [2:0] {
    PGS_SEQ_IDLE = 3'b000,
    PGS_SEQ_WAIT = 3'b001,
    PGS_SEQ_HOLD = 3'b010,
    PGS_SEQ_EXTRA = 3'b011,
    PGS_SEQ_FIN = 3'b100
  } pgs_seq_t;

endpackage : pgs_pkg

// ---- rtl/pgs_supervisor.sv ----
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - main ok released only when enabled rails good
// - relaxed mode: undervoltage only, 1 ms/10 us
// - tight mode undervoltage: 50 us fall, 10 us rise
// - tight mode adds overvoltage: 50 us/1 ms
// - main ok low after reset and with no rails
// - disabled rails are ignored entirely
// - 5 ms blanking after each rail enable
// - release delay after sequencer finishes
// - qualified fault drops ok at once, powers down
// - software disable of a rail other than the last does not drop ok
// - ok drops when last enabled rail disabled
// - any power-down trigger drops ok
// - ok held low while suspended
// - backup ok is push-pull, high when both good
// - backup ok is plain AND, registered one cycle
// - backup fault has no shutdown effect
// - backup rails recover with no software action
// - sequencer waits for late rail, then 1 ms
module pgs_supervisor import pgs_pkg::*; #(
  parameter int BLANK_CYC = CYC_BLANK,
  parameter int DEG_SLOW_CYC = CYC_DEG_SLOW,
  parameter int DEG_FAST_CYC = CYC_DEG_FAST,
  parameter int STROBE_CYC = CYC_STROBE,
  parameter int HOLD_EXTRA_CYC = CYC_HOLD_EXTRA,
  parameter int DLY_UNIT_CYC = CYC_DLY_UNIT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NRAIL-1:0] rail_uv_low,
  input wire logic [NRAIL-1:0] rail_ov_high,
  input wire logic backup_a_good,
  input wire logic backup_b_good,
  input wire logic seq_start,
  input wire logic pd_trigger_in,
  input wire logic suspend,
  output logic [3:0] buck_rail_on,
  output logic linear_rail_on,
  output logic strict_window,
  input wire logic main_rails_ok_in,
  output logic main_rails_ok_out,
  output logic main_rails_ok_oe,
  output logic backup_rails_ok,
  output logic pd_request
);

  typedef struct packed {
    logic [NRAIL-1:0] rail_en;
    logic [NRAIL-1:0] en_q;
    logic strict;
    logic [7:0] ok_release_delay;
    logic fault_sticky;
    pgs_ok_t ok_st;
    pgs_seq_t seq_st;
    logic [2:0] seq_idx;
    logic tmr_go;
    logic [TMR_W-1:0] tmr_lim;
    logic rel_go;
    logic oe;
    logic bk_ok;
    logic pd_req;
    logic [31:0] rdata;
  } pgs_state_t;

  pgs_state_t s;
  pgs_state_t next_s;

  logic [NRAIL-1:0] blank_done;
  logic [NRAIL-1:0] uv_bad;
  logic [NRAIL-1:0] ov_bad;
  logic [NRAIL-1:0] monitored;
  logic [NRAIL-1:0] rail_bad;
  logic fault;
  logic seq_done;
  logic rel_done;
  logic [DG_W-1:0] uv_set_cyc;

  // Disabled rails are masked off before anything looks at them
  assign monitored = s.rail_en & blank_done;
  assign rail_bad = uv_bad | (ov_bad & {NRAIL{s.strict}});
  assign fault = |(monitored & rail_bad);
  assign uv_set_cyc = s.strict ? DG_W'(DEG_FAST_CYC)
                               : DG_W'(DEG_SLOW_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < NRAIL; gi++) begin : g_rail
      pgs_delay_timer u_blank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(s.rail_en[gi] & ~s.en_q[gi]),
        .stop(~s.rail_en[gi]),
        .limit(TMR_W'(BLANK_CYC)),
        .done(blank_done[gi])
      );
      // Idle or blanked rail forgets its old verdict at once, so a
      // ramp or an earlier fault cannot trip it when blanking ends
      pgs_deglitch u_uv (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw_bad(rail_uv_low[gi] & s.rail_en[gi] & blank_done[gi]),
        .set_cyc(uv_set_cyc),
        .clr_cyc(blank_done[gi] ? DG_W'(CYC_DEG_RISE) : DG_W'(1)),
        .bad(uv_bad[gi])
      );
      // Overvoltage is only looked at in the tight window
      pgs_deglitch u_ov (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw_bad(rail_ov_high[gi] & s.rail_en[gi] & s.strict
          & blank_done[gi]),
        .set_cyc(DG_W'(DEG_FAST_CYC)),
        .clr_cyc(blank_done[gi] ? DG_W'(DEG_SLOW_CYC) : DG_W'(1)),
        .bad(ov_bad[gi])
      );
    end
  endgenerate

  pgs_delay_timer u_seq_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(s.tmr_go),
    .stop(s.seq_st == PGS_SEQ_IDLE),
    .limit(s.tmr_lim),
    .done(seq_done)
  );

  pgs_delay_timer u_rel_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(s.rel_go),
    .stop(s.ok_st != PGS_OK_WAIT),
    .limit(TMR_W'(s.ok_release_delay * DLY_UNIT_CYC)),
    .done(rel_done)
  );

  always_comb begin
    logic advance;
    logic drop;
    logic [2:0] nidx;
    next_s = s;
    advance = 1'b0;
    drop = 1'b0;
    nidx = s.seq_idx + 3'h1;
    next_s.tmr_go = 1'b0;
    next_s.rel_go = 1'b0;
    next_s.pd_req = 1'b0;
    next_s.rdata = '0;
    next_s.en_q = s.rail_en;

    // Register writes; enables are locked while the sequencer runs
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        if (s.seq_st == PGS_SEQ_IDLE) begin
          next_s.rail_en = reg_wdata[NRAIL-1:0];
        end
        next_s.strict = reg_wdata[CTRL_STRICT_BIT];
      end else if (reg_addr == REG_DELAY) begin
        next_s.ok_release_delay = reg_wdata[7:0];
      end else if (reg_addr == REG_STATUS) begin
        if (reg_wdata[STAT_FAULT_BIT]) begin
          next_s.fault_sticky = 1'b0;
        end
      end
    end

    // Power-up sequencer, one rail per strobe in index order
    case (s.seq_st)
      PGS_SEQ_IDLE: begin
        if (seq_start && !suspend) begin
          next_s.seq_idx = 3'h0;
          next_s.rail_en[0] = 1'b1;
          next_s.tmr_go = 1'b1;
          next_s.tmr_lim = TMR_W'(STROBE_CYC);
          next_s.seq_st = PGS_SEQ_WAIT;
        end
      end
      PGS_SEQ_WAIT: begin
        if (!s.tmr_go && seq_done) begin
          if (!rail_uv_low[s.seq_idx]) begin
            advance = 1'b1;
          end else begin
            next_s.seq_st = PGS_SEQ_HOLD;
          end
        end
      end
      PGS_SEQ_HOLD: begin
        // Late rail: wait for it, then add a settling gap
        if (!rail_uv_low[s.seq_idx]) begin
          next_s.tmr_go = 1'b1;
          next_s.tmr_lim = TMR_W'(HOLD_EXTRA_CYC);
          next_s.seq_st = PGS_SEQ_EXTRA;
        end
      end
      PGS_SEQ_EXTRA: begin
        if (!s.tmr_go && seq_done) begin
          advance = 1'b1;
        end
      end
      PGS_SEQ_FIN: begin
        next_s.seq_st = PGS_SEQ_IDLE;
      end
      default: begin
        next_s.seq_st = PGS_SEQ_IDLE;
      end
    endcase

    if (advance) begin
      if (s.seq_idx == LAST_RAIL) begin
        next_s.seq_st = PGS_SEQ_FIN;
      end else begin
        next_s.seq_idx = nidx;
        next_s.rail_en[nidx] = 1'b1;
        next_s.tmr_go = 1'b1;
        next_s.tmr_lim = TMR_W'(STROBE_CYC);
        next_s.seq_st = PGS_SEQ_WAIT;
      end
    end

    // A qualified fault shuts every main rail down and asks for power-down
    if (fault) begin
      next_s.rail_en = '0;
      next_s.pd_req = 1'b1;
      next_s.fault_sticky = 1'b1;
      next_s.seq_st = PGS_SEQ_IDLE;
    end

    // Looks at the enables after this cycle's write, so the last
    // disable drops the output in the same edge
    drop = fault || pd_trigger_in || suspend
      || (next_s.rail_en == '0);

    if (drop) begin
      next_s.ok_st = PGS_OK_LOW;
    end else begin
      case (s.ok_st)
        PGS_OK_LOW: begin
          if (s.seq_st == PGS_SEQ_FIN) begin
            next_s.ok_st = PGS_OK_WAIT;
            next_s.rel_go = 1'b1;
          end
        end
        PGS_OK_WAIT: begin
          if (!s.rel_go && rel_done) begin
            next_s.ok_st = PGS_OK_HIGH;
          end
        end
        PGS_OK_HIGH: begin
          next_s.ok_st = PGS_OK_HIGH;
        end
        default: begin
          next_s.ok_st = PGS_OK_LOW;
        end
      endcase
    end
    next_s.oe = (next_s.ok_st != PGS_OK_HIGH);

    // Backup rails only report; no path into shutdown or main ok
    next_s.bk_ok = backup_a_good & backup_b_good;

    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        next_s.rdata[NRAIL-1:0] = s.rail_en;
        next_s.rdata[CTRL_STRICT_BIT] = s.strict;
      end else if (reg_addr == REG_DELAY) begin
        next_s.rdata[7:0] = s.ok_release_delay;
      end else if (reg_addr == REG_STATUS) begin
        next_s.rdata[NRAIL-1:0] = monitored & ~rail_bad;
        next_s.rdata[STAT_OK_BIT] = (s.ok_st == PGS_OK_HIGH);
        next_s.rdata[STAT_BK_BIT] = s.bk_ok;
        next_s.rdata[STAT_FAULT_BIT] = s.fault_sticky;
        next_s.rdata[STAT_PIN_BIT] = main_rails_ok_in;
      end
    end
    if (fault) begin
      next_s.fault_sticky = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ok_release_delay <= RST_DELAY;
      s.ok_st <= PGS_OK_LOW;
      s.seq_st <= PGS_SEQ_IDLE;
      s.oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign buck_rail_on = s.rail_en[3:0];
  assign linear_rail_on = s.rail_en[4];
  assign strict_window = s.strict;
  assign main_rails_ok_out = OD_LEVEL;
  assign main_rails_ok_oe = s.oe;
  assign backup_rails_ok = s.bk_ok;
  assign pd_request = s.pd_req;

endmodule : pgs_supervisor
`default_nettype wire

// ---- verification/pgs_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module pgs_checker import pgs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic backup_a_good,
  input wire logic backup_b_good,
  input wire logic pd_trigger_in,
  input wire logic suspend,
  input wire logic [3:0] buck_rail_on,
  input wire logic linear_rail_on,
  input wire logic main_rails_ok_out,
  input wire logic main_rails_ok_oe,
  input wire logic backup_rails_ok,
  input wire logic pd_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic any_on = (|buck_rail_on) | linear_rail_on;
  sequence s_drop;
    suspend || pd_trigger_in;
  endsequence
  sequence s_fault;
    pd_request ##1 !pd_request;
  endsequence
  chk_drive_zero: assert property (main_rails_ok_out == 1'h0)
    else $error("ok pin drive level not low");
  chk_reset_low: assert property ($rose(rst_n) |-> main_rails_ok_oe)
    else $error("ok pin released at reset exit");
  chk_drop_low: assert property (s_drop |=> main_rails_ok_oe)
    else $error("ok pin not pulled low on drop cause");
  chk_none_low: assert property (!any_on |-> main_rails_ok_oe)
    else $error("ok pin released with no rail on");
  chk_fault_low: assert property (pd_request |-> main_rails_ok_oe && !any_on)
    else $error("fault did not pull ok low and stop rails");
  chk_pulse_one: assert property (pd_request |-> s_fault)
    else $error("power down request longer than one cycle");
  chk_release_ok: assert property ($fell(main_rails_ok_oe) |->
    any_on && !$past(suspend) && !$past(pd_trigger_in))
    else $error("ok pin released while a drop cause stood");
  chk_backup_and: assert property (1'h1 |=> backup_rails_ok ==
    ($past(backup_a_good) && $past(backup_b_good)))
    else $error("backup ok is not the and of both rails");
  chk_backup_quiet: assert property ($fell(backup_rails_ok) |-> !pd_request
    && $stable(main_rails_ok_oe))
    else $error("backup fault disturbed main rails");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : pgs_checker
bind pgs_supervisor pgs_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .backup_a_good(backup_a_good),
  .backup_b_good(backup_b_good), .pd_trigger_in(pd_trigger_in),
  .suspend(suspend), .buck_rail_on(buck_rail_on),
  .linear_rail_on(linear_rail_on), .main_rails_ok_out(main_rails_ok_out),
  .main_rails_ok_oe(main_rails_ok_oe), .backup_rails_ok(backup_rails_ok),
  .pd_request(pd_request));
`default_nettype wire

// ---- verification/pgs_rail_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pgs_rail_model import pgs_pkg::*; #(
  parameter int RAMP_CYC = 10,
  parameter int SLOW_CYC = 45
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NRAIL-1:0] rail_en,
  input wire logic [NRAIL-1:0] slow_mask,
  input wire logic [NRAIL-1:0] uv_force,
  input wire logic [NRAIL-1:0] ov_force,
  input wire logic pull_dn,
  output logic [NRAIL-1:0] uv_low,
  output logic [NRAIL-1:0] ov_high,
  output logic pin_level
);
  int ramp [NRAIL];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    for (int i = 0; i < NRAIL; i++) begin
      if (!rst_n || !rail_en[i]) begin
        ramp[i] <= 0;
      end else if (ramp[i] < 255) begin
        ramp[i] <= ramp[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NRAIL; i++) begin
      // Off or still ramping reads below threshold
      uv_low[i] = !rail_en[i] || uv_force[i] ||
        ramp[i] < (slow_mask[i] ? SLOW_CYC : RAMP_CYC);
      ov_high[i] = rail_en[i] && ov_force[i];
    end
  end
  // Pull-up on the host reset line
  assign pin_level = !pull_dn;
endmodule : pgs_rail_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench import pgs_pkg::*;;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic rd_d = 1'h0;
  logic [NRAIL-1:0] uv, ov, slow = 5'h04, uv_f = 5'h00, ov_f = 5'h00;
  logic ba = 1'h1, bb = 1'h1, seq_go = 1'h0, pd_trig = 1'h0, susp = 1'h0;
  logic [31:0] reg_rdata;
  logic [3:0] buck_on;
  logic lin_on, ok_in, ok_oe, bk_ok, pd_req, a, b, strict_o, ok_out;
  int err_count = 0, tests_run = 0, cyc = 0, n;
  logic [31:0] exp_q [$];
  always #5 ref_clk = ~ref_clk;
  // Fast and rise deglitch kept at their real length; the others are shortened
  pgs_supervisor #(.BLANK_CYC(50), .DEG_SLOW_CYC(20),
    .STROBE_CYC(30), .HOLD_EXTRA_CYC(10), .DLY_UNIT_CYC(5)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rail_uv_low(uv), .rail_ov_high(ov),
    .backup_a_good(ba), .backup_b_good(bb), .seq_start(seq_go),
    .pd_trigger_in(pd_trig), .suspend(susp), .buck_rail_on(buck_on),
    .linear_rail_on(lin_on), .strict_window(strict_o),
    .main_rails_ok_in(ok_in), .main_rails_ok_out(ok_out),
    .main_rails_ok_oe(ok_oe),
    .backup_rails_ok(bk_ok), .pd_request(pd_req));
  pgs_rail_model rails (.ref_clk(ref_clk), .rst_n(rst_n),
    .rail_en({lin_on, buck_on}), .slow_mask(slow), .uv_force(uv_f),
    .ov_force(ov_f), .pull_dn(ok_oe), .uv_low(uv), .ov_high(ov),
    .pin_level(ok_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'h0;
  endtask : rd
  task automatic wait_oe(input logic v);
    n = 0;
    while (ok_oe !== v && n < 900) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_oe
  task automatic wait_pd;
    n = 0;
    while (pd_req !== 1'h1 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_pd
  task automatic power_up;
    @(posedge ref_clk);
    seq_go <= 1'h1;
    @(posedge ref_clk);
    seq_go <= 1'h0;
    while (uv[2] !== 1'h1 || buck_on[2] !== 1'h1) @(negedge ref_clk);
    while (uv[2] !== 1'h0) @(negedge ref_clk);
    n = 0;
    while (buck_on[3] !== 1'h1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 10 && n < 16, 1);
    while (lin_on !== 1'h1) @(negedge ref_clk);
    wait_oe(1'h0);
    // Last strobe, then release delay of one unit
    chk(n >= 37 && n < 44, 1);
    chk(ok_oe, 1'h0);
  endtask : power_up
  task automatic stop_test;
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    cyc++;
    // Whole run is near 5800 cycles
    if (cyc == 12000) begin
      err_count++;
      stop_test();
    end
  end
  always @(negedge ref_clk) begin
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h1BC2F4C0));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    chk(ok_oe, 1'h1);
    rd(REG_DELAY, 32'h0A);
    rd(8'h40, 32'h0);
    wr(REG_DELAY, 32'h1);
    power_up();
    repeat (60) @(posedge ref_clk);
    rd(REG_STATUS, 32'h17F);
    chk({strict_o, ok_out}, 2'h0);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      a = 1'($urandom);
      b = 1'($urandom);
      ba <= a;
      bb <= b;
      @(posedge ref_clk);
      #1;
      chk(bk_ok, a & b);
      chk(ok_oe, 1'h0);
    end
    ba <= 1'h1;
    bb <= 1'h1;
    wr(REG_CTRL, 32'h1E);
    repeat (40) @(posedge ref_clk);
    chk({bk_ok, ok_oe}, 2'h2);
    uv_f[3] <= 1'h1;
    repeat (15) @(posedge ref_clk);
    uv_f[3] <= 1'h0;
    repeat (30) @(posedge ref_clk);
    chk(ok_oe, 1'h0);
    uv_f[3] <= 1'h1;
    wait_pd();
    chk(n >= 19 && n < 26, 1);
    chk(ok_oe, 1'h1);
    uv_f[3] <= 1'h0;
    wr(REG_CTRL, 32'h100);
    power_up();
    repeat (60) @(posedge ref_clk);
    chk({strict_o, ok_out}, 2'h2);
    ov_f[1] <= 1'h1;
    repeat (6) @(posedge ref_clk);
    ov_f[1] <= 1'h0;
    repeat (20) @(posedge ref_clk);
    chk(ok_oe, 1'h0);
    susp <= 1'h1;
    repeat (2) @(posedge ref_clk);
    chk(ok_oe, 1'h1);
    susp <= 1'h0;
    pd_trig <= 1'h1;
    @(posedge ref_clk);
    pd_trig <= 1'h0;
    ov_f[1] <= 1'h1;
    wait_pd();
    chk(n >= CYC_DEG_FAST && n < CYC_DEG_FAST + 6, 1);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
